//--- hw/qdd_top.sv
`timescale 1ns/10ps
// Quadrature downconverter and decimation chain
module qdd_top (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic [4:0] ADC_DATA,
   input wire logic SYSREF,
   input wire logic [9:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   output logic [7:0] REG_RDATA,
   output logic CALC_BUSY,
   output logic signed [15:0] OUT_I,
   output logic signed [15:0] OUT_Q,
   output logic OUT_VALID
);
   localparam int W = qdd_pkg::DATA_W;

   typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_FINISH} qdd_calc_t;

   // Configuration registers
   logic [2:0] dec_sel_q;
   logic [15:0] rate_q;
   logic [15:0] if_q;
   logic [5:0] coarse_word_q;
   logic [7:0] fine_word_q;
   logic [5:0] coarse_phase_q;
   logic [9:0] fine_phase_q;
   logic [7:0] rdata_d;

   // Address decode
   logic wr_sel;
   logic wr_rate_lo;
   logic wr_rate_hi;
   logic wr_if_lo;
   logic wr_if_hi;
   logic wr_coarse;
   logic wr_fine;
   logic wr_cph;
   logic wr_fph_lo;
   logic wr_fph_hi;

   assign wr_sel = REG_WR && (REG_ADDR == qdd_pkg::ADDR_DEC_SEL);
   assign wr_rate_lo = REG_WR && (REG_ADDR == qdd_pkg::ADDR_RATE_LO);
   assign wr_rate_hi = REG_WR && (REG_ADDR == qdd_pkg::ADDR_RATE_HI);
   assign wr_if_lo = REG_WR && (REG_ADDR == qdd_pkg::ADDR_IF_LO);
   assign wr_if_hi = REG_WR && (REG_ADDR == qdd_pkg::ADDR_IF_HI);
   assign wr_coarse = REG_WR && (REG_ADDR == qdd_pkg::ADDR_COARSE_FREQ);
   assign wr_fine = REG_WR && (REG_ADDR == qdd_pkg::ADDR_FINE_FREQ);
   assign wr_cph = REG_WR && (REG_ADDR == qdd_pkg::ADDR_COARSE_PHASE);
   assign wr_fph_lo = REG_WR && (REG_ADDR == qdd_pkg::ADDR_FINE_PHASE_LO);
   assign wr_fph_hi = REG_WR && (REG_ADDR == qdd_pkg::ADDR_FINE_PHASE_HI);

   // Mode decode: stage one factor and fourth stage use
   logic div3;
   logic use_s4;
   logic [2:0] s1_factor;

   assign div3 = (dec_sel_q == qdd_pkg::SEL_DEC24) || (dec_sel_q == qdd_pkg::SEL_DEC12);
   assign use_s4 = (dec_sel_q == qdd_pkg::SEL_DEC32) || (dec_sel_q == qdd_pkg::SEL_DEC24);
   assign s1_factor = div3 ? qdd_pkg::FACTOR_THREE : qdd_pkg::FACTOR_FOUR;

   // Word calculator: ratio = IF / rate with 16 fraction bits
   qdd_calc_t state_q;
   logic [4:0] step_q;
   logic [16:0] rem_q;
   logic [15:0] quo_q;
   logic [15:0] num_q;
   logic [16:0] rem_shift;
   logic rem_ge;
   logic [6:0] coarse_full;
   logic [17:0] ratio_x3;
   logic [11:0] fine_4096;
   logic [11:0] fine_3072;
   logic [11:0] fine_calc;
   logic calc_start;
   logic [15:0] if_next;

   assign calc_start = wr_sel || wr_if_hi || wr_rate_hi;
   // IF as it stands after this edge, so a hi-byte write is used at once
   assign if_next = {(wr_if_hi ? REG_WDATA : if_q[15:8]), if_q[7:0]};
   assign rem_shift = {rem_q[15:0], num_q[15]};
   assign rem_ge = (rem_shift >= {1'b0, rate_q});
   // Round(64 x ratio), one extra bit so a carry to 64 is kept
   assign coarse_full = 7'((17'(quo_q) + 17'h00200) >> 10);
   assign ratio_x3 = 18'(quo_q) * 18'h3;
   // Round(M x ratio) minus coarse share, M = 4096 or 3072
   assign fine_4096 = 12'((17'(quo_q) + 17'h00008) >> 4) - 12'({coarse_full, 6'h00});
   assign fine_3072 = 12'((ratio_x3 + 18'h00020) >> 6) - 12'(coarse_full * 7'd48);
   assign fine_calc = div3 ? fine_3072 : fine_4096;

   // Sequential restoring divide, then load both words
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         state_q <= ST_IDLE;
         step_q <= 5'h00;
         rem_q <= '0;
         quo_q <= '0;
         num_q <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (calc_start) begin
                  state_q <= ST_DIVIDE;
                  step_q <= 5'h00;
                  rem_q <= {1'b0, if_next};
                  num_q <= '0;
                  quo_q <= '0;
               end
            end
            ST_DIVIDE: begin
               rem_q <= rem_ge ? 17'(rem_shift - {1'b0, rate_q}) : rem_shift;
               quo_q <= {quo_q[14:0], rem_ge};
               num_q <= {num_q[14:0], 1'b0};
               step_q <= step_q + 5'h01;
               if (step_q == qdd_pkg::DIV_STEPS - 5'h01) begin
                  state_q <= ST_FINISH;
               end
            end
            ST_FINISH: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Software registers; computed words override a same-cycle write
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         dec_sel_q <= qdd_pkg::RST_DEC_SEL;
         rate_q <= qdd_pkg::RST_RATE;
         if_q <= qdd_pkg::RST_IF;
         coarse_word_q <= 6'h00;
         fine_word_q <= 8'h00;
         coarse_phase_q <= 6'h00;
         fine_phase_q <= 10'h000;
      end else begin
         if (wr_sel) dec_sel_q <= REG_WDATA[2:0];
         if (wr_rate_lo) rate_q[7:0] <= REG_WDATA;
         if (wr_rate_hi) rate_q[15:8] <= REG_WDATA;
         if (wr_if_lo) if_q[7:0] <= REG_WDATA;
         if (wr_if_hi) if_q[15:8] <= REG_WDATA;
         if (wr_cph) coarse_phase_q <= REG_WDATA[5:0];
         if (wr_fph_lo) fine_phase_q[7:0] <= REG_WDATA;
         if (wr_fph_hi) fine_phase_q[9:8] <= REG_WDATA[1:0];
         if (state_q == ST_FINISH) begin
            coarse_word_q <= coarse_full[5:0];
            fine_word_q <= fine_calc[7:0];
         end else begin
            if (wr_coarse) coarse_word_q <= REG_WDATA[5:0];
            if (wr_fine) fine_word_q <= REG_WDATA;
         end
      end
   end

   // Read mux, registered
   always_comb begin
      unique case (REG_ADDR)
         qdd_pkg::ADDR_RATE_LO: rdata_d = rate_q[7:0];
         qdd_pkg::ADDR_RATE_HI: rdata_d = rate_q[15:8];
         qdd_pkg::ADDR_IF_LO: rdata_d = if_q[7:0];
         qdd_pkg::ADDR_IF_HI: rdata_d = if_q[15:8];
         qdd_pkg::ADDR_DEC_SEL: rdata_d = {5'h00, dec_sel_q};
         qdd_pkg::ADDR_COARSE_FREQ: rdata_d = {2'h0, coarse_word_q};
         qdd_pkg::ADDR_FINE_FREQ: rdata_d = fine_word_q;
         qdd_pkg::ADDR_COARSE_PHASE: rdata_d = {2'h0, coarse_phase_q};
         qdd_pkg::ADDR_FINE_PHASE_LO: rdata_d = fine_phase_q[7:0];
         qdd_pkg::ADDR_FINE_PHASE_HI: rdata_d = {6'h00, fine_phase_q[9:8]};
         qdd_pkg::ADDR_STATUS: rdata_d = {7'h00, state_q != ST_IDLE};
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         REG_RDATA <= 8'h00;
         CALC_BUSY <= 1'b0;
      end else begin
         REG_RDATA <= rdata_d;
         CALC_BUSY <= (state_q != ST_IDLE) || calc_start;
      end
   end

   // Sync pulse: three flops, edge once second and third agree high
   logic [qdd_pkg::SYNC_DEPTH-1:0] sync_q;
   logic sync_seen_q;
   logic sync_pulse;

   assign sync_pulse = sync_q[1] && sync_q[2] && !sync_seen_q;

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         sync_q <= '0;
         sync_seen_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[1:0], SYSREF};
         if (sync_q[1] == sync_q[2]) sync_seen_q <= sync_q[2];
      end
   end

   // Coarse mixer on every converter sample
   logic signed [7:0] c_cos;
   logic signed [7:0] c_sin;
   logic signed [4:0] adc_q;
   logic signed [W-1:0] coarse_frequency_word_i_q;
   logic signed [W-1:0] coarse_frequency_word_q_q;

   qdd_nco #(.PW(6)) u_coarse_nco (
      .clk(CORE_CLK),
      .rst(RESET),
      .step_en(1'b1),
      .inc(coarse_word_q),
      .load(sync_pulse),
      .init(coarse_phase_q),
      .cos_q(c_cos),
      .sin_q(c_sin)
   );

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         adc_q <= 5'sh00;
         coarse_frequency_word_i_q <= '0;
         coarse_frequency_word_q_q <= '0;
      end else begin
         adc_q <= ADC_DATA;
         coarse_frequency_word_i_q <= W'(adc_q * c_cos);
         coarse_frequency_word_q_q <= W'(-(adc_q * c_sin));
      end
   end

   // Four decimating stages per rail, fine mixer after the first
   logic [3:0] sv;
   logic signed [W-1:0] si [4];
   logic signed [W-1:0] sq [4];
   logic signed [W-1:0] in_i [4];
   logic signed [W-1:0] in_q [4];
   logic in_v [4];
   logic signed [7:0] f_cos;
   logic signed [7:0] f_sin;
   logic signed [W-1:0] fine_frequency_word_i_q;
   logic signed [W-1:0] fine_frequency_word_q_q;
   logic fine_frequency_word_v_q;
   logic signed [W+8:0] f_i;
   logic signed [W+8:0] f_q;

   assign in_i[0] = coarse_frequency_word_i_q;
   assign in_q[0] = coarse_frequency_word_q_q;
   assign in_v[0] = 1'b1;
   assign in_i[1] = fine_frequency_word_i_q;
   assign in_q[1] = fine_frequency_word_q_q;
   assign in_v[1] = fine_frequency_word_v_q;
   assign in_i[2] = si[1];
   assign in_q[2] = sq[1];
   assign in_v[2] = sv[1];
   assign in_i[3] = si[2];
   assign in_q[3] = sq[2];
   assign in_v[3] = sv[2];

   // Fine step is fine/M of rate = fine/1024 per stage-one sample
   qdd_nco #(.PW(10)) u_fine_nco (
      .clk(CORE_CLK),
      .rst(RESET),
      .step_en(sv[0]),
      .inc({{2{fine_word_q[7]}}, fine_word_q}),
      .load(sync_pulse),
      .init(fine_phase_q),
      .cos_q(f_cos),
      .sin_q(f_sin)
   );

   // Rotate by minus the fine phase
   assign f_i = (W+9)'(si[0] * f_cos) + (W+9)'(sq[0] * f_sin);
   assign f_q = (W+9)'(sq[0] * f_cos) - (W+9)'(si[0] * f_sin);

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         fine_frequency_word_i_q <= '0;
         fine_frequency_word_q_q <= '0;
         fine_frequency_word_v_q <= 1'b0;
      end else begin
         fine_frequency_word_v_q <= sv[0];
         if (sv[0]) begin
            fine_frequency_word_i_q <= f_i[W+6:7];
            fine_frequency_word_q_q <= f_q[W+6:7];
         end
      end
   end

   for (genvar s = 0; s < 4; s++) begin : g_stage
      logic [2:0] fac;
      assign fac = (s == 0) ? s1_factor : qdd_pkg::FACTOR_TWO;
      qdd_decim #(.W(W)) u_dec_i (
         .clk(CORE_CLK),
         .rst(RESET),
         .in_valid(in_v[s]),
         .in_data(in_i[s]),
         .factor(fac),
         .out_valid(sv[s]),
         .out_data(si[s])
      );
      qdd_decim #(.W(W)) u_dec_q (
         .clk(CORE_CLK),
         .rst(RESET),
         .in_valid(in_v[s]),
         .in_data(in_q[s]),
         .factor(fac),
         .out_valid(),
         .out_data(sq[s])
      );
   end

   // Output select: bypass fourth stage for 12 and 16
   logic out_v;
   logic signed [W-1:0] out_i;
   logic signed [W-1:0] out_q;

   assign out_v = use_s4 ? sv[3] : sv[2];
   assign out_i = use_s4 ? si[3] : si[2];
   assign out_q = use_s4 ? sq[3] : sq[2];

   // Fixed pipeline: no stall anywhere, so latency is constant
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         OUT_I <= 16'sh0000;
         OUT_Q <= 16'sh0000;
         OUT_VALID <= 1'b0;
      end else begin
         OUT_VALID <= out_v;
         if (out_v) begin
            OUT_I <= out_i[W-1:W-16];
            OUT_Q <= out_q[W-1:W-16];
         end
      end
   end
endmodule : qdd_top

//--- hw/qdd_pkg.sv
// Operation
// - Accept 5-bit oversampled real converter samples.
// - Coarse mixer on input, fine after stage one.
// - Coarse tuning 6 bits, fine tuning 8 bits.
// - Select code 1..4 gives factors 32,24,16,12.
// - Composite step is rate/3072 or rate/4096.
// - Compute both mixer words on a select, IF hi-byte or rate hi-byte write.
// - Coarse word is round(64 x IF/rate).
// - Fine word is round(M x residual), signed.
// - Coarse start phase on sync, 1/64 steps.
// - Fine start phase on sync, 1/1024 steps.
// - First stage decimates by 3 or 4.
// - Stages two and three each decimate by 2.
// - Fourth stage bypassed for 12 and 16.
// - All stages use symmetric linear-phase coefficients.
// - Converter to output latency is fixed.
package qdd_pkg;
   // Register offsets
   localparam logic [9:0] ADDR_RATE_LO = 10'h100;
   localparam logic [9:0] ADDR_RATE_HI = 10'h101;
   localparam logic [9:0] ADDR_IF_LO = 10'h102;
   localparam logic [9:0] ADDR_IF_HI = 10'h103;
   localparam logic [9:0] ADDR_DEC_SEL = 10'h140;
   localparam logic [9:0] ADDR_COARSE_FREQ = 10'h141;
   localparam logic [9:0] ADDR_FINE_FREQ = 10'h142;
   localparam logic [9:0] ADDR_COARSE_PHASE = 10'h143;
   localparam logic [9:0] ADDR_FINE_PHASE_LO = 10'h144;
   localparam logic [9:0] ADDR_FINE_PHASE_HI = 10'h145;
   localparam logic [9:0] ADDR_STATUS = 10'h146;
   // Reset values
   localparam logic [2:0] RST_DEC_SEL = 3'h1;
   localparam logic [15:0] RST_RATE = 16'h0c80;
   localparam logic [15:0] RST_IF = 16'h008c;
   // Decimation select codes
   localparam logic [2:0] SEL_DEC32 = 3'h1;
   localparam logic [2:0] SEL_DEC24 = 3'h2;
   localparam logic [2:0] SEL_DEC16 = 3'h3;
   localparam logic [2:0] SEL_DEC12 = 3'h4;
   // Stage factors
   localparam logic [2:0] FACTOR_THREE = 3'h3;
   localparam logic [2:0] FACTOR_FOUR = 3'h4;
   localparam logic [2:0] FACTOR_TWO = 3'h2;
   // Ratio fraction bits and divider steps
   localparam int RATIO_FRAC = 16;
   localparam logic [4:0] DIV_STEPS = 5'h10;
   // Internal data width and sync depth
   localparam int DATA_W = 20;
   localparam int SYNC_DEPTH = 3;
endpackage : qdd_pkg

//--- hw/qdd_nco.sv
`timescale 1ns/10ps
// Phase accumulator with 16-point quadrature lookup
module qdd_nco #(
   parameter int PW = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic step_en,
   input wire logic [PW-1:0] inc,
   input wire logic load,
   input wire logic [PW-1:0] init,
   output logic signed [7:0] cos_q,
   output logic signed [7:0] sin_q
);
   logic [PW-1:0] phase_q;
   logic [3:0] idx;
   logic [3:0] idx_cos;

   // Sine table, quarter turn of 4 entries mirrored
   function automatic logic signed [7:0] sine(input logic [3:0] k);
      logic [1:0] q;
      logic signed [7:0] m;
      q = k[1:0];
      m = 8'sh00;
      unique case (k[3] ? (k[2] ? 2'(3'h4 - {1'b0, q}) : q) : (k[2] ? 2'(3'h4 - {1'b0, q}) : q))
         2'h0: m = k[2] ? 8'sh7f : 8'sh00;
         2'h1: m = 8'sh31;
         2'h2: m = 8'sh5a;
         2'h3: m = 8'sh75;
      endcase
      if (k[2] && q == 2'h0) begin
         m = 8'sh7f;
      end
      sine = k[3] ? -m : m;
   endfunction : sine

   assign idx = phase_q[PW-1 -: 4];
   assign idx_cos = idx + 4'h4;

   // Load start phase on sync, otherwise advance
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= '0;
         cos_q <= 8'sh00;
         sin_q <= 8'sh00;
      end else begin
         if (load) begin
            phase_q <= init;
         end else if (step_en) begin
            phase_q <= phase_q + inc;
         end
         cos_q <= sine(idx_cos);
         sin_q <= sine(idx);
      end
   end
endmodule : qdd_nco

//--- hw/qdd_decim.sv
`timescale 1ns/10ps
// Boxcar decimator: all-ones taps, symmetric and linear phase
module qdd_decim #(
   parameter int W = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic signed [W-1:0] in_data,
   input wire logic [2:0] factor,
   output logic out_valid,
   output logic signed [W-1:0] out_data
);
   logic signed [W+1:0] acc_q;
   logic [2:0] cnt_q;
   logic last;
   logic signed [W+1:0] sum;

   assign last = (cnt_q == factor - 3'h1);
   assign sum = acc_q + {{2{in_data[W-1]}}, in_data};

   // Accumulate factor samples, dump scaled sum
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
         cnt_q <= 3'h0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         out_valid <= in_valid && last;
         if (in_valid) begin
            if (last) begin
               acc_q <= '0;
               cnt_q <= 3'h0;
               out_data <= (factor > qdd_pkg::FACTOR_TWO) ? sum[W+1:2] : sum[W:1];
            end else begin
               acc_q <= sum;
               cnt_q <= cnt_q + 3'h1;
            end
         end
      end
   end
endmodule : qdd_decim

//--- testbench/qdd_top_asserts.sv
`timescale 1ns/10ps
// Port-level checks of the register port and the output stream
module qdd_top_asserts (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic [4:0] ADC_DATA,
   input wire logic SYSREF,
   input wire logic [9:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic [7:0] REG_RDATA,
   input wire logic CALC_BUSY,
   input wire logic signed [15:0] OUT_I,
   input wire logic signed [15:0] OUT_Q,
   input wire logic OUT_VALID
);
   logic [2:0] sel_q;
   logic [5:0] gap_q;
   logic [2:0] nval_q;
   logic wr_sel;
   logic mapped;
   logic [5:0] fac_m1;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // Watched writes, address map and expected output gap
   assign wr_sel = REG_WR && (REG_ADDR == qdd_pkg::ADDR_DEC_SEL);
   assign mapped = (REG_ADDR[9:2] == 8'h40) ||
      ((REG_ADDR >= qdd_pkg::ADDR_DEC_SEL) && (REG_ADDR <= qdd_pkg::ADDR_STATUS));
   assign fac_m1 = (sel_q == qdd_pkg::SEL_DEC32) ? 6'h1f :
      (sel_q == qdd_pkg::SEL_DEC24) ? 6'h17 : (sel_q == qdd_pkg::SEL_DEC16) ? 6'h0f : 6'h0b;
   // Tracks select, cycles since last output and settled outputs
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         sel_q <= qdd_pkg::RST_DEC_SEL;
         gap_q <= 6'h00;
         nval_q <= 3'h0;
      end else begin
         gap_q <= OUT_VALID ? 6'h00 : gap_q + 6'h01;
         if (wr_sel) begin
            sel_q <= REG_WDATA[2:0];
            nval_q <= 3'h0;
         end else if (OUT_VALID && (nval_q != 3'h7)) begin
            nval_q <= nval_q + 3'h1;
         end
      end
   end
   a_unmapped_read: assert property (
      !mapped |=> REG_RDATA == 8'h00) else $error("Unmapped read not zero");
   a_sel_readback: assert property (
      wr_sel ##1 (REG_ADDR == qdd_pkg::ADDR_DEC_SEL && !REG_WR)
      |=> REG_RDATA[2:0] == $past(REG_WDATA[2:0], 2)) else $error("Select readback wrong");
   a_calc_start: assert property (
      wr_sel |=> CALC_BUSY) else $error("Word computation not started");
   a_calc_bound: assert property (
      $rose(CALC_BUSY) |-> ##[1:60] !CALC_BUSY) else $error("Word computation too long");
   a_valid_single: assert property (
      OUT_VALID && nval_q == 3'h7 |=> !OUT_VALID [*8]) else $error("Output pulses too close");
   a_period_exact: assert property (
      OUT_VALID && nval_q == 3'h7 |-> gap_q == fac_m1) else $error("Output period wrong");
   a_out_hold: assert property (
      !OUT_VALID |-> $stable(OUT_I) && $stable(OUT_Q)) else $error("Output changed without valid");
   a_phase_readback: assert property (
      REG_WR && REG_ADDR == qdd_pkg::ADDR_COARSE_PHASE ##1
      (REG_ADDR == qdd_pkg::ADDR_COARSE_PHASE && !REG_WR)
      |=> REG_RDATA[5:0] == $past(REG_WDATA[5:0], 2)) else $error("Phase readback wrong");
endmodule : qdd_top_asserts
bind qdd_top qdd_top_asserts u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .ADC_DATA(ADC_DATA),
   .SYSREF(SYSREF), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RDATA(REG_RDATA), .CALC_BUSY(CALC_BUSY), .OUT_I(OUT_I), .OUT_Q(OUT_Q),
   .OUT_VALID(OUT_VALID));

//--- testbench/qdd_adc_model.sv
`timescale 1ns/10ps
// Converter model: one 5-bit signed sample per clock, a 23-clock square tone
module qdd_adc_model (
   input wire logic clk,
   input wire logic rst,
   output logic [4:0] sample
);
   logic [4:0] ph_q;
   // Tone phase counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q <= 5'h00;
      end else begin
         ph_q <= (ph_q == 5'h16) ? 5'h00 : ph_q + 5'h01;
      end
   end
   // Plus twelve for 11 clocks, then minus twelve for 12
   assign sample = (ph_q < 5'h0b) ? 5'h0c : 5'h14;
endmodule : qdd_adc_model

//--- testbench/qdd_top_tb_top.sv
`timescale 1ns/10ps
// Register-driven tests of the downconverter and decimation chain
module qdd_top_tb_top;
   logic core_clk, reset, sysref, reg_wr, calc_busy, out_valid;
   logic [4:0] adc_data;
   logic [9:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic signed [15:0] out_i, out_q;
   logic [7:0] fine_tab [1:4] = '{8'hf3, 8'hf6, 8'hf3, 8'hf6};
   logic [7:0] fac_tab [1:4] = '{8'h20, 8'h18, 8'h10, 8'h0c};
   int err_total, checks, cycles, k;
   // Clock at 25 MHz
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   qdd_top DUT (.CORE_CLK(core_clk), .RESET(reset), .ADC_DATA(adc_data), .SYSREF(sysref),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RDATA(reg_rdata),
      .CALC_BUSY(calc_busy), .OUT_I(out_i), .OUT_Q(out_q), .OUT_VALID(out_valid));
   qdd_adc_model u_adc (.clk(core_clk), .rst(reset), .sample(adc_data));
   task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8
   task chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk16
   task wr_reg(input logic [9:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [9:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      @(posedge core_clk);
      @(posedge core_clk);
      #1 v = reg_rdata;
   endtask : rd_reg
   task wait_idle();
      int n;
      n = 0;
      @(posedge core_clk);
      #1;
      while (calc_busy !== 1'b0 && n < 100) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk8("calc_busy", 8'h00, {7'h00, calc_busy});
   endtask : wait_idle
   task next_valid(output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         #1 c++;
      end while (out_valid !== 1'b1 && c < 200);
   endtask : next_valid
   task test_done();
      $display("Checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   // Cuts a hang short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      reset = 1'b1;
      sysref = 1'b0;
      reg_addr = 10'h000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      err_total = 0;
      checks = 0;
      cycles = 0;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      // Reset values and an unmapped place
      rd_reg(qdd_pkg::ADDR_DEC_SEL, d);
      chk8("select reset", 8'h01, d & 8'h07);
      rd_reg(qdd_pkg::ADDR_RATE_LO, d);
      chk8("rate lo reset", 8'h80, d);
      rd_reg(qdd_pkg::ADDR_RATE_HI, d);
      chk8("rate hi reset", 8'h0c, d);
      rd_reg(qdd_pkg::ADDR_IF_LO, d);
      chk8("if lo reset", 8'h8c, d);
      rd_reg(10'h3ff, d);
      chk8("unmapped", 8'h00, d);
      $display("Test reset values done");
      // Mixer words and output period for every select code
      for (int c = 1; c <= 4; c++) begin
         wr_reg(qdd_pkg::ADDR_DEC_SEL, 8'(c));
         wait_idle();
         rd_reg(qdd_pkg::ADDR_DEC_SEL, d);
         chk8("select", 8'(c), d & 8'h07);
         rd_reg(qdd_pkg::ADDR_COARSE_FREQ, d);
         chk8("coarse word", 8'h03, d & 8'h3f);
         rd_reg(qdd_pkg::ADDR_FINE_FREQ, d);
         chk8("fine word", fine_tab[c], d);
         repeat (4) next_valid(k);
         next_valid(k);
         chk8("valid gap", fac_tab[c], 8'(k));
      end
      $display("Test select codes done");
      // New IF of 170, lo byte then hi byte back to back
      wr_reg(qdd_pkg::ADDR_IF_LO, 8'haa);
      wr_reg(qdd_pkg::ADDR_IF_HI, 8'h00);
      wait_idle();
      rd_reg(qdd_pkg::ADDR_COARSE_FREQ, d);
      chk8("coarse word new if", 8'h03, d & 8'h3f);
      rd_reg(qdd_pkg::ADDR_FINE_FREQ, d);
      chk8("fine word new if", 8'h13, d);
      $display("Test new IF done");
      // Start phases, then a sync pulse with the stream running
      wr_reg(qdd_pkg::ADDR_COARSE_PHASE, 8'h2a);
      rd_reg(qdd_pkg::ADDR_COARSE_PHASE, d);
      chk8("coarse start", 8'h2a, d & 8'h3f);
      wr_reg(qdd_pkg::ADDR_FINE_PHASE_LO, 8'h55);
      wr_reg(qdd_pkg::ADDR_FINE_PHASE_HI, 8'h02);
      rd_reg(qdd_pkg::ADDR_FINE_PHASE_HI, d);
      chk8("fine start hi", 8'h02, d & 8'h03);
      rd_reg(qdd_pkg::ADDR_FINE_PHASE_LO, d);
      chk8("fine start lo", 8'h55, d);
      @(posedge core_clk);
      sysref <= 1'b1;
      repeat (6) @(posedge core_clk);
      sysref <= 1'b0;
      repeat (3) next_valid(k);
      next_valid(k);
      chk8("gap after sync", 8'h0c, 8'(k));
      $display("Test sync done");
      // Zero tuning and zero start phases: a real input leaves Q at zero
      wr_reg(qdd_pkg::ADDR_COARSE_FREQ, 8'h00);
      wr_reg(qdd_pkg::ADDR_FINE_FREQ, 8'h00);
      wr_reg(qdd_pkg::ADDR_COARSE_PHASE, 8'h00);
      wr_reg(qdd_pkg::ADDR_FINE_PHASE_LO, 8'h00);
      wr_reg(qdd_pkg::ADDR_FINE_PHASE_HI, 8'h00);
      rd_reg(qdd_pkg::ADDR_FINE_FREQ, d);
      chk8("fine word written", 8'h00, d);
      @(posedge core_clk);
      sysref <= 1'b1;
      repeat (6) @(posedge core_clk);
      sysref <= 1'b0;
      repeat (8) next_valid(k);
      chk16("q at zero tuning", 16'h0000, out_q);
      next_valid(k);
      chk16("q held at zero", 16'h0000, out_q);
      $display("Test zero tuning done");
      test_done();
   end
endmodule : qdd_top_tb_top
